// ---- timer_unit.sv ----
// Timer unit with one-shot pulse and PWM output modes behind an APB register slave.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "timer_unit_defines.svh"

module timer_unit
  import timer_unit_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire apb_req_s    apb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        trig_i,
  output logic [3:0]       pin_o,
  output logic             period_irq_o,
  output logic [2:0]       channel_irq_o
);

  timer_state_s st_reg;
  timer_state_s st_next;

  logic [6:0]  presc_mask;
  logic        tick;
  logic        edge_rise;
  logic        edge_fall;
  logic        ext_trig;
  logic        wr_acc;
  logic        setup;
  logic        sw_trig;
  logic [2:0]  mode;
  logic        cnt_en;

  // The count clock is the core clock divided by a power of two.
  assign presc_mask = 7'h7f >> (3'd7 - st_reg.ctrl0[`CKS_MSB:`CKS_LSB]);
  assign tick       = ((st_reg.presc & presc_mask) == presc_mask);

  // Edge detection reads only the second synchroniser stage.
  assign edge_rise  = st_reg.trig_sync[1] & ~st_reg.trig_prev;
  assign edge_fall  = ~st_reg.trig_sync[1] & st_reg.trig_prev;
  assign ext_trig   =
    ((st_reg.ioc2[`TES_MSB:`TES_LSB] == `EDGE_RISING)  & edge_rise) |
    ((st_reg.ioc2[`TES_MSB:`TES_LSB] == `EDGE_FALLING) & edge_fall) |
    ((st_reg.ioc2[`TES_MSB:`TES_LSB] == `EDGE_BOTH)    & (edge_rise | edge_fall));

  assign setup   = apb_i.psel & ~apb_i.penable;
  assign wr_acc  = apb_i.psel & apb_i.penable & st_reg.pready & apb_i.pwrite;
  assign sw_trig = wr_acc & (apb_i.paddr == `OFS_CONTROL_REGISTER_1) &
                   apb_i.pwdata[`BIT_SOFTWARE_TRIGGER];
  assign mode    = st_reg.ctrl1[`MODE_MSB:`MODE_LSB];
  assign cnt_en  = st_reg.ctrl0[`BIT_COUNT_ENABLE];

  always_comb begin
    logic [15:0] step;
    logic [3:0]  level;
    step  = 16'h0000;
    level = 4'h0;
    st_next = st_reg;
    st_next.irq = 4'h0;
    st_next.presc = 7'(st_reg.presc + 7'h01);
    st_next.trig_sync = {st_reg.trig_sync[0], trig_i};
    st_next.trig_prev = st_reg.trig_sync[1];

    if (!cnt_en || (mode != `MODE_ONE_SHOT && mode != `MODE_PWM)) begin
      st_next.run  = ST_IDLE;
      st_next.cnt  = `COUNTER_PARKED;
      st_next.chan = 4'h0;
    end else if (mode == `MODE_ONE_SHOT) begin
      case (st_reg.run)
        ST_IDLE: begin
          st_next.run  = ST_WAIT;
          st_next.cnt  = `COUNTER_PARKED;
          st_next.chan = 4'h0;
        end
        ST_WAIT: begin
          if (ext_trig || sw_trig) begin
            st_next.run     = ST_RUN;
            st_next.first   = 1'b1;
            st_next.chan[0] = 1'b1;
          end
        end
        ST_RUN: begin
          // Triggers are not looked at here, so a retrigger mid-pulse is lost.
          if (tick) begin
            if (!st_reg.first && st_reg.cnt == st_reg.ccr[0]) begin
              st_next.run    = ST_WAIT;
              st_next.cnt    = `COUNTER_PARKED;
              st_next.chan   = 4'h0;
              st_next.irq[0] = 1'b1;
            end else begin
              step = st_reg.first ? `COUNTER_CLEARED : 16'(st_reg.cnt + 16'h0001);
              st_next.cnt   = step;
              st_next.first = 1'b0;
              for (int k = 1; k < 4; k++) begin
                if (step == st_reg.ccr[k]) begin
                  st_next.chan[k] = 1'b1;
                  st_next.irq[k]  = 1'b1;
                end
              end
            end
          end
        end
        default: st_next.run = ST_IDLE;
      endcase
    end else begin
      case (st_reg.run)
        ST_IDLE: begin
          st_next.run   = ST_RUN;
          st_next.first = 1'b1;
          st_next.cnt   = `COUNTER_PARKED;
          st_next.chan  = 4'h0;
        end
        ST_RUN: begin
          if (tick) begin
            if (st_reg.first || st_reg.cnt == st_reg.buffer[0]) begin
              st_next.cnt     = `COUNTER_CLEARED;
              st_next.first   = 1'b0;
              st_next.irq[0]  = ~st_reg.first;
              st_next.chan[0] = ~st_reg.chan[0];
              if (st_reg.first || st_reg.reload_pend) begin
                st_next.buffer      = st_reg.ccr;
                st_next.reload_pend = 1'b0;
              end
              for (int k = 1; k < 4; k++) begin
                st_next.chan[k] = (st_next.buffer[k] != `COUNTER_CLEARED);
                st_next.irq[k]  = (st_next.buffer[k] == `COUNTER_CLEARED);
              end
            end else begin
              step = 16'(st_reg.cnt + 16'h0001);
              st_next.cnt = step;
              for (int k = 1; k < 4; k++) begin
                if (step == st_reg.buffer[k]) begin
                  st_next.chan[k] = 1'b0;
                  st_next.irq[k]  = 1'b1;
                end
              end
            end
          end
        end
        default: st_next.run = ST_IDLE;
      endcase
    end

    // Bus slave: no wait states, since ready, read data and error leave flip-flops loaded in the setup cycle.
    st_next.pready  = setup;
    st_next.pslverr = 1'b0;
    st_next.prdata  = 32'h0000_0000;
    if (setup) begin
      case (apb_i.paddr)
        `OFS_CONTROL_REGISTER_0:    st_next.prdata = {24'h000000, st_reg.ctrl0};
        // The software trigger bit always reads back as zero.
        `OFS_CONTROL_REGISTER_1:    st_next.prdata = {24'h000000, st_reg.ctrl1};
        `OFS_PIN_OUTPUT_CONTROL:    st_next.prdata = {24'h000000, st_reg.ioc0};
        `OFS_IO_CONTROL_REGISTER_1: st_next.prdata = {24'h000000, st_reg.ioc1};
        `OFS_INPUT_EDGE_SELECT:     st_next.prdata = {24'h000000, st_reg.ioc2};
        `OFS_OPTION_REGISTER_0:     st_next.prdata = {24'h000000, st_reg.opt0};
        `OFS_COUNTER_READ_BUFFER:   st_next.prdata = {16'h0000, st_reg.cnt};
        `OFS_COMPARE_CHANNEL_0:     st_next.prdata = {16'h0000, st_reg.ccr[0]};
        `OFS_COMPARE_CHANNEL_1:     st_next.prdata = {16'h0000, st_reg.ccr[1]};
        `OFS_COMPARE_CHANNEL_2:     st_next.prdata = {16'h0000, st_reg.ccr[2]};
        `OFS_COMPARE_CHANNEL_3:     st_next.prdata = {16'h0000, st_reg.ccr[3]};
        default:                    st_next.pslverr = 1'b1;
      endcase
    end

    if (wr_acc) begin
      case (apb_i.paddr)
        `OFS_CONTROL_REGISTER_0: st_next.ctrl0 = apb_i.pwdata[7:0] & 8'h87;
        `OFS_CONTROL_REGISTER_1: st_next.ctrl1 = {5'h00, apb_i.pwdata[2:0]};
        `OFS_PIN_OUTPUT_CONTROL: st_next.ioc0  = apb_i.pwdata[7:0];
        `OFS_IO_CONTROL_REGISTER_1: st_next.ioc1 = apb_i.pwdata[7:0];
        `OFS_INPUT_EDGE_SELECT:  st_next.ioc2  = {4'h0, apb_i.pwdata[3:0]};
        `OFS_OPTION_REGISTER_0:  st_next.opt0  = apb_i.pwdata[7:0];
        `OFS_COMPARE_CHANNEL_0:  st_next.ccr[0] = apb_i.pwdata[15:0];
        `OFS_COMPARE_CHANNEL_1: begin
          st_next.ccr[1] = apb_i.pwdata[15:0];
          st_next.reload_pend = 1'b1;
        end
        `OFS_COMPARE_CHANNEL_2:  st_next.ccr[2] = apb_i.pwdata[15:0];
        `OFS_COMPARE_CHANNEL_3:  st_next.ccr[3] = apb_i.pwdata[15:0];
        default:                 st_next.ctrl0 = st_reg.ctrl0;
      endcase
    end

    // Pins follow the next channel state so they change with the interrupts.
    for (int k = 0; k < 4; k++) begin
      level[k] = st_reg.ioc0[2 * k + 1];
      if (st_reg.ioc0[2 * k]) begin
        // polarity on outputs one to three
        st_next.pin[k] = (k == 0) ? st_next.chan[k] : (st_next.chan[k] ^ level[k]);
      end else begin
        st_next.pin[k] = (k == 0) ? level[k] : 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_reg     <= '0;
      st_reg.cnt <= `COUNTER_PARKED;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata_o      = st_reg.prdata;
  assign pready_o      = st_reg.pready;
  assign pslverr_o     = st_reg.pslverr;
  assign pin_o         = st_reg.pin;
  assign period_irq_o  = st_reg.irq[0];
  assign channel_irq_o = st_reg.irq[3:1];

  AST_OS_ENABLE_WAITS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cnt_en && mode == `MODE_ONE_SHOT && st_reg.run == ST_IDLE)
      |=> (st_reg.run == ST_WAIT && st_reg.cnt == `COUNTER_PARKED))
    else $error("one-shot enable did not enter trigger wait");

  AST_DISABLE_STOPS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!cnt_en) |=> (st_reg.run == ST_IDLE && st_reg.cnt == `COUNTER_PARKED && st_reg.chan == 4'h0))
    else $error("clearing count enable did not stop the counter");

  AST_OS_PULSE_END: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cnt_en && mode == `MODE_ONE_SHOT && st_reg.run == ST_RUN && tick && !st_reg.first &&
     st_reg.cnt == st_reg.ccr[0])
      |=> (st_reg.run == ST_WAIT && st_reg.cnt == `COUNTER_PARKED && period_irq_o))
    else $error("one-shot pulse did not end at channel zero match");

  AST_CHANNEL_IRQ_AT_MATCH: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (channel_irq_o[0] && mode == `MODE_PWM && st_reg.cnt != `COUNTER_CLEARED)
      |-> (st_reg.cnt == st_reg.buffer[1] && !st_reg.chan[1] && $past(st_reg.chan[1])))
    else $error("channel one interrupt not aligned with its match");

  AST_OS_IRQ_WITH_PIN: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (channel_irq_o[1] && mode == `MODE_ONE_SHOT)
      |-> (st_reg.cnt == st_reg.ccr[2] && st_reg.chan[2]))
    else $error("one-shot channel two interrupt not with pin assert");

  AST_PWM_PERIOD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cnt_en && mode == `MODE_PWM && st_reg.run == ST_RUN && tick && !st_reg.first &&
     st_reg.cnt == st_reg.buffer[0])
      |=> (period_irq_o && st_reg.cnt == `COUNTER_CLEARED &&
           st_reg.chan[0] != $past(st_reg.chan[0])))
    else $error("PWM period end missed clear, interrupt or toggle");

  AST_RELOAD_ONLY_AT_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_reg.buffer != $past(st_reg.buffer)) |-> (st_reg.cnt == `COUNTER_CLEARED))
    else $error("compare buffers changed away from counter clear");

  AST_OUT0_DISABLED_LEVEL: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!st_reg.ioc0[0]) |=> (pin_o[0] == $past(st_reg.ioc0[1])))
    else $error("disabled output zero does not show its level bit");

  AST_POLARITY_CH1: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_reg.ioc0[2]) |=> (pin_o[1] == (st_reg.chan[1] ^ $past(st_reg.ioc0[3]))))
    else $error("output one polarity wrong");

  AST_COUNTER_READ: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (setup && apb_i.paddr == `OFS_COUNTER_READ_BUFFER)
      |=> (pready_o && prdata_o == {16'h0000, $past(st_reg.cnt)}))
    else $error("counter read returned a stale value");

  AST_PWM_ENABLE_PARKS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cnt_en && mode == `MODE_PWM && st_reg.run == ST_IDLE)
      |=> (st_reg.run == ST_RUN && st_reg.first && st_reg.cnt == `COUNTER_PARKED))
    else $error("PWM enable did not start from the parked count");

  AST_PWM_FIRST_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cnt_en && mode == `MODE_PWM && st_reg.run == ST_RUN && tick && st_reg.first)
      |=> (st_reg.cnt == `COUNTER_CLEARED && !st_reg.first && !period_irq_o))
    else $error("PWM start did not step the counter to zero");

  AST_PWM_SET_AT_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cnt_en && mode == `MODE_PWM && st_reg.run == ST_RUN && tick &&
     (st_reg.first || st_reg.cnt == st_reg.buffer[0]))
      |=> (st_reg.chan[1] == (st_reg.buffer[1] != `COUNTER_CLEARED)))
    else $error("PWM channel one not set at counter clear");

  // Without a channel one write the old buffers stay, so a half-done update of
  // channels two and three never reaches the pins.
  AST_PWM_NO_RELOAD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cnt_en && mode == `MODE_PWM && st_reg.run == ST_RUN && tick && !st_reg.first &&
     st_reg.cnt == st_reg.buffer[0] && !st_reg.reload_pend)
      |=> (st_reg.buffer == $past(st_reg.buffer)))
    else $error("compare buffers reloaded without a channel one write");

  AST_PWM_RELOAD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cnt_en && mode == `MODE_PWM && st_reg.run == ST_RUN && tick && !st_reg.first &&
     st_reg.cnt == st_reg.buffer[0] && st_reg.reload_pend)
      |=> (st_reg.buffer == $past(st_reg.ccr)))
    else $error("compare buffers did not take the written compares");

  AST_OS_TRIGGER_STARTS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cnt_en && mode == `MODE_ONE_SHOT && st_reg.run == ST_WAIT && (ext_trig || sw_trig))
      |=> (st_reg.run == ST_RUN && st_reg.first && st_reg.chan[0]))
    else $error("trigger did not start the one-shot pulse");

  AST_OS_RETRIGGER_IGNORED: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cnt_en && mode == `MODE_ONE_SHOT && st_reg.run == ST_RUN && !st_reg.first &&
     (ext_trig || sw_trig))
      |=> (!st_reg.first && st_reg.run != ST_IDLE))
    else $error("trigger during a one-shot pulse restarted it");

  AST_OS_IRQ1_WITH_PIN: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (channel_irq_o[0] && mode == `MODE_ONE_SHOT)
      |-> (st_reg.cnt == st_reg.ccr[1] && st_reg.chan[1]))
    else $error("one-shot channel one interrupt not with pin assert");

  AST_OUT0_SQUARE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_reg.ioc0[0]) |=> (pin_o[0] == st_reg.chan[0]))
    else $error("enabled output zero does not follow its square wave");

  AST_OUT1_DISABLED: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!st_reg.ioc0[2]) |=> (pin_o[1] == 1'b0))
    else $error("disabled output one is not low");

  AST_CTRL0_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (wr_acc && apb_i.paddr == `OFS_CONTROL_REGISTER_0)
      |=> (cnt_en == $past(apb_i.pwdata[`BIT_COUNT_ENABLE]) &&
           st_reg.ctrl0[`CKS_MSB:`CKS_LSB] == $past(apb_i.pwdata[`CKS_MSB:`CKS_LSB])))
    else $error("enable and clock select not taken in one write");

endmodule // timer_unit

// ---- timer_unit_defines.svh ----
// Register offsets, field positions, reset values and mode codes of the timer unit.
//
// Functional notes
// - Clock select and count enable are accepted together in one write.
// - One-shot compare writes reach the comparators at once.
// - One-shot: enable enters trigger wait; clearing enable stops counting.
// - Shrunk one-shot compares act immediately; counter wraps past FFFFH and finishes.
// - One-shot channel interrupt fires when count equals compare, with the pin.
// - Mode 100 selects PWM; enable drives waveforms on outputs one to three.
// - PWM output zero toggles once per period.
// - PWM enable steps counter FFFFH to 0000H and starts the waveform.
// - PWM period is channel zero plus one; width is channel value.
// - PWM compare updates take effect only at counter clear.
// - PWM period interrupt fires on the step after the channel zero match.
// - PWM channel interrupt fires in the clock the count equals its buffer.
// - Each output enable bit disables its pin at 0, enables at 1.
// - Outputs one to three: level bit 0 active high, 1 active low.
// - Output zero level bit sets the pin while disabled: 0 low, 1 high.
// - Reading the counter register returns the live 16-bit count.
// - I/O control register 1 and option register 0 do nothing here.
// - Compare registers two and three transfer only at PWM start or after channel one is written.
// - Mode 011 selects one-shot; enable leaves the timer waiting for trigger.
// - One-shot trigger runs counter from 0000H, parks at FFFFH; retriggers ignored.
// - One-shot delay equals channel value; width is channel zero minus it plus one.
// - A one-shot trigger is the chosen external edge or software trigger bit.
`ifndef TIMER_UNIT_DEFINES_SVH
`define TIMER_UNIT_DEFINES_SVH

`define OFS_CONTROL_REGISTER_0   8'h00
`define OFS_CONTROL_REGISTER_1   8'h04
`define OFS_PIN_OUTPUT_CONTROL   8'h08
`define OFS_IO_CONTROL_REGISTER_1 8'h0c
`define OFS_INPUT_EDGE_SELECT    8'h10
`define OFS_OPTION_REGISTER_0    8'h14
`define OFS_COUNTER_READ_BUFFER  8'h18
`define OFS_COMPARE_CHANNEL_0    8'h1c
`define OFS_COMPARE_CHANNEL_1    8'h20
`define OFS_COMPARE_CHANNEL_2    8'h24
`define OFS_COMPARE_CHANNEL_3    8'h28

`define BIT_COUNT_ENABLE         7
`define CKS_MSB                  2
`define CKS_LSB                  0
`define BIT_SOFTWARE_TRIGGER     6
`define MODE_MSB                 2
`define MODE_LSB                 0
`define TES_MSB                  1
`define TES_LSB                  0

`define MODE_ONE_SHOT            3'b011
`define MODE_PWM                 3'b100

`define EDGE_RISING              2'h1
`define EDGE_FALLING             2'h2
`define EDGE_BOTH                2'h3

`define COUNTER_PARKED           16'hffff
`define COUNTER_CLEARED          16'h0000

`endif

// ---- timer_unit_pkg.sv ----
// Types shared by the timer unit: bus request carrier, run states and the state record.
package timer_unit_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} run_state_e;

  typedef struct packed {
    run_state_e       run;
    logic             first;
    logic [15:0]      cnt;
    logic [6:0]       presc;
    logic [1:0]       trig_sync;
    logic             trig_prev;
    logic [7:0]       ctrl0;
    logic [7:0]       ctrl1;
    logic [7:0]       ioc0;
    logic [7:0]       ioc1;
    logic [7:0]       ioc2;
    logic [7:0]       opt0;
    logic [3:0][15:0] ccr;
    logic [3:0][15:0] buffer;
    logic             reload_pend;
    logic [3:0]       chan;
    logic [3:0]       pin;
    logic [3:0]       irq;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } timer_state_s;

endpackage

// ---- pin_monitor.sv ----
// External circuit model: trigger source and pulse meter on the timer pins.
`timescale 1ns/10ps
module pin_monitor (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  pin_i,
  input  wire logic        fire_i,
  output logic             trig_o,
  output logic [15:0]      width_o,
  output logic [15:0]      period_o,
  output logic [15:0]      toggle_o
);
  logic [15:0] hi_cnt;
  logic [15:0] per_cnt;
  logic [15:0] tog_cnt;
  logic [1:0]  prev;
  logic [2:0]  stretch;
  // external trigger edge
  // The level is held for six cycles so it survives the two-flop synchroniser.
  assign trig_o = (stretch != 3'h0);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      {hi_cnt, per_cnt, tog_cnt} <= '0;
      {width_o, period_o, toggle_o} <= '0;
      prev <= 2'h0;
      stretch <= 3'h0;
    end else begin
      prev <= pin_i[1:0];
      stretch <= fire_i ? 3'h6 : stretch - {2'h0, (stretch != 3'h0)};
      hi_cnt <= pin_i[1] ? hi_cnt + 16'h1 : 16'h0;
      if (!pin_i[1] && prev[1]) begin
        width_o <= hi_cnt;
      end
      per_cnt <= (pin_i[1] && !prev[1]) ? 16'h1 : per_cnt + 16'h1;
      if (pin_i[1] && !prev[1]) begin
        period_o <= per_cnt;
      end
      tog_cnt <= (pin_i[0] != prev[0]) ? 16'h1 : tog_cnt + 16'h1;
      if (pin_i[0] != prev[0]) begin
        toggle_o <= tog_cnt;
      end
    end
  end
endmodule // pin_monitor

// ---- testbench.sv ----
// Self-checking bench for the timer unit: registers, PWM and one-shot output.
`timescale 1ns/10ps
`include "timer_unit_defines.svh"
module testbench
  import timer_unit_pkg::*;
;
  logic        core_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  apb_req_s    apb = '0;
  logic        fire = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        trig_i;
  logic [3:0]  pin_o;
  logic        period_irq_o;
  logic [2:0]  channel_irq_o;
  logic [15:0] width;
  logic [15:0] period;
  logic [15:0] toggle;
  logic [31:0] rdata;
  logic        err;
  int          num_errors = 0;
  int          compares = 0;
  always #5 core_clk_i = ~core_clk_i;
  timer_unit u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .apb_i(apb),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .trig_i(trig_i),
    .pin_o(pin_o), .period_irq_o(period_irq_o), .channel_irq_o(channel_irq_o));
  pin_monitor u_pins (.clk_i(core_clk_i), .rst_b_i(rst_b_i), .pin_i(pin_o), .fire_i(fire),
    .trig_o(trig_i), .width_o(width), .period_o(period), .toggle_o(toggle));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("Mismatches %0d, comparisons %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    $display("Error at %0t: wait ran out", $time);
    test_done();
  endtask
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk_i);
    apb.penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge core_clk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 16) timeout();
    rdata = prdata_o;
    err = pslverr_o;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask
  // Index 0 waits for the period interrupt, 1 to 3 for a channel interrupt.
  task automatic wait_irq(input int k);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk_i);
      #1;
      if ((k == 0) ? period_irq_o === 1'b1 : channel_irq_o[k-1] === 1'b1) break;
    end
    if (n == 200) timeout();
  endtask
  task automatic hold(input int k, input logic v, input int cycles);
    int bad = 0;
    repeat (cycles) begin
      @(posedge core_clk_i);
      #1;
      if (pin_o[k] !== v) bad++;
    end
    check(bad, 0);
  endtask
  task automatic fire_trigger();
    @(posedge core_clk_i);
    fire <= 1'b1;
    @(posedge core_clk_i);
    fire <= 1'b0;
  endtask
  task automatic reg_test();
    rd(`OFS_COUNTER_READ_BUFFER, 32'hffff);
    wr(`OFS_COUNTER_READ_BUFFER, 32'h1234);
    rd(`OFS_COUNTER_READ_BUFFER, 32'hffff);
    wr(`OFS_IO_CONTROL_REGISTER_1, 32'h5a);
    rd(`OFS_IO_CONTROL_REGISTER_1, 32'h5a);
    apb_xfer(1'b0, 8'h2c, 32'h0);
    check(err, 1'b1);
  endtask
  task automatic pwm_test();
    wr(`OFS_CONTROL_REGISTER_1, 32'h4);
    wr(`OFS_PIN_OUTPUT_CONTROL, 32'h75);
    wr(`OFS_INPUT_EDGE_SELECT, 32'hc);
    wr(`OFS_COMPARE_CHANNEL_0, 32'h9);
    wr(`OFS_COMPARE_CHANNEL_2, 32'h0);
    wr(`OFS_COMPARE_CHANNEL_3, 32'ha);
    wr(`OFS_COMPARE_CHANNEL_1, 32'h3);
    wr(`OFS_CONTROL_REGISTER_0, 32'h80);
    wait_irq(0);
    check(pin_o[1], 1'b1);
    wait_irq(1);
    check(pin_o[1], 1'b0);
    hold(3, 1'b1, 25);
    check(pin_o[2], 1'b1);
    check(width, 16'h3);
    check(period, 16'ha);
    check(toggle, 16'ha);
    apb_xfer(1'b0, `OFS_COUNTER_READ_BUFFER, 32'h0);
    check({31'h0, rdata <= 32'h9}, 32'h1);
    wr(`OFS_COMPARE_CHANNEL_2, 32'h4);
    hold(2, 1'b1, 25);
    wr(`OFS_COMPARE_CHANNEL_1, 32'h5);
    repeat (30) @(posedge core_clk_i);
    check(width, 16'h5);
    wr(`OFS_PIN_OUTPUT_CONTROL, 32'h2);
    repeat (2) @(posedge core_clk_i);
    check(pin_o, 4'h1);
    wr(`OFS_CONTROL_REGISTER_0, 32'h0);
    rd(`OFS_COUNTER_READ_BUFFER, 32'hffff);
  endtask
  task automatic oneshot_test();
    wr(`OFS_CONTROL_REGISTER_1, 32'h3);
    wr(`OFS_PIN_OUTPUT_CONTROL, 32'h55);
    wr(`OFS_INPUT_EDGE_SELECT, 32'h1);
    wr(`OFS_COMPARE_CHANNEL_0, 32'h8);
    wr(`OFS_COMPARE_CHANNEL_1, 32'h3);
    wr(`OFS_COMPARE_CHANNEL_3, 32'h6);
    wr(`OFS_CONTROL_REGISTER_0, 32'h81);
    rd(`OFS_COUNTER_READ_BUFFER, 32'hffff);
    wr(`OFS_CONTROL_REGISTER_1, 32'h43);
    wait_irq(1);
    check(pin_o[1], 1'b1);
    wait_irq(3);
    check(pin_o[3], 1'b1);
    wait_irq(0);
    check(pin_o[1], 1'b0);
    repeat (2) @(posedge core_clk_i);
    check(width, 16'hc);
    rd(`OFS_COUNTER_READ_BUFFER, 32'hffff);
    // raising a compare value is allowed while waiting
    wr(`OFS_COMPARE_CHANNEL_1, 32'h5);
    fire_trigger();
    wait_irq(1);
    check(pin_o[1], 1'b1);
    fire_trigger();
    wait_irq(0);
    repeat (2) @(posedge core_clk_i);
    check(width, 16'h8);
    rd(`OFS_COUNTER_READ_BUFFER, 32'hffff);
    // The trigger only starts the pulse on its falling edge here.
    wr(`OFS_INPUT_EDGE_SELECT, 32'h2);
    fire_trigger();
    wait_irq(1);
    check(pin_o[1], 1'b1);
    wait_irq(0);
    check(pin_o[1], 1'b0);
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    reg_test();
    pwm_test();
    oneshot_test();
    test_done();
  end
endmodule // testbench
